/* File: design/pfsk_core.v */
// What this block does
// - slot clock ticks per data pulse and per missing-pulse interval
// - key strobe lags slot tick by an adjustable phase delay
// - slot tick advances countdown; decode drives one key line per gate
// - each main key line high one slot, low rest of frame
// - each subcom key line high one slot, low eight frames minus one
// - a slot without data pulse gives a sync candidate
// - candidate ANDed with candidate eight slots earlier gives frame sync
// - validated sync realigns countdown so gate 1 meets channel 1
// - after lock, main gate accepts sync only in expected slot
// - expected sync arriving closes gate until next expected slot
// - missing expected sync leaves gate open until sync re-established
// - closed gate rejects false and subcom sync pulses
// - candidate ANDed with previous slot candidate flags subcom sync
// - subcom candidates pass only in channel 1 slot once locked
// - subcom gate works like main gate using subcom countdown
// - main and subcom gate inputs ORed onto record line
`timescale 1ns/1ps
`include "pfsk_map.vh"
module pfsk_core #(
  parameter SLOT_CYC = `PFSK_SLOT_CYC,
  parameter PH_W     = 16
) (
  // clock and reset
  input  wire            core_clk,
  input  wire            rst_n,
  // incoming pulse train and phase trim
  input  wire            data_pulse,
  input  wire [PH_W-1:0] phase_dly,
  // keying lines
  output reg  [31:0]     hf_key_q,
  output reg  [7:0]      sc_key_q,
  // sync status and record line
  output reg             slot_clk_q,
  output reg             sync_cand_q,
  output reg             frame_lock_q,
  output reg             sub_lock_q,
  output reg             sync_rec_q
);

  // ******************************************************************
  // frame constants
  // ******************************************************************
  // slot and frame positions used by gates, countdowns and keys
  localparam [4:0]  LAST_CH  = `PFSK_LAST_CH;
  localparam [4:0]  MAIN_EXP = `PFSK_MAIN_EXP_CH;
  localparam [4:0]  SUB_EXP  = `PFSK_SUB_EXP_CH;
  localparam [4:0]  SUB_GATE = `PFSK_SUB_GATE_CH;
  localparam [4:0]  REALIGN  = `PFSK_REALIGN_CH;
  localparam [4:0]  SC_KEY   = `PFSK_SC_KEY_CH;
  localparam [2:0]  SUB_SF   = `PFSK_SUB_EXP_SF;
  localparam [15:0] HALF_CYC = SLOT_CYC / 2;
  localparam [15:0] LAST_CYC = SLOT_CYC - 1;
  localparam        DLY_TOP  = `PFSK_MAIN_DLY - 1;

  // ******************************************************************
  // helpers
  // ******************************************************************
  // one-hot decode of a 5-bit index
  function [31:0] pfsk_dec;
    input [4:0] idx;
    begin
      pfsk_dec = 32'h0000_0001 << idx;
    end
  endfunction

  // true in the last slot of the frame
  function pfsk_last;
    input [4:0] idx;
    begin
      pfsk_last = (idx == LAST_CH);
    end
  endfunction

  // ******************************************************************
  // slot clock recovery
  // ******************************************************************
  reg  [15:0]     scnt_q;
  reg             pulse_d_q;
  reg             seen_q;
  reg             tick;
  reg             miss;
  wire            edge_in;
  wire            late_half;

  // rising edge of the train and late half of the slot
  assign edge_in   = data_pulse & ~pulse_d_q;
  assign late_half = (scnt_q >= HALF_CYC);

  // flywheel tick on timeout, early tick on a pulse in the late half
  always @* begin
    tick = 1'b0;
    miss = 1'b0;
    if (edge_in && late_half) begin
      tick = 1'b1;
    end else if (scnt_q == LAST_CYC) begin
      tick = 1'b1;
      miss = ~seen_q & ~edge_in;
    end
  end

  // slot counter, restarted by every tick or early pulse
  always @(posedge core_clk) begin
    if (!rst_n) begin
      scnt_q    <= 16'h0000;
      pulse_d_q <= 1'b0;
    end else begin
      pulse_d_q <= data_pulse;
      if (tick || (edge_in && !late_half)) begin
        scnt_q <= 16'h0000;
      end else begin
        scnt_q <= scnt_q + 16'h0001;
      end
    end
  end

  // a pulse in the early half marks the slot as filled
  always @(posedge core_clk) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else if (tick) begin
      seen_q <= 1'b0;
    end else if (edge_in) begin
      seen_q <= 1'b1;
    end
  end

  // ******************************************************************
  // sync validation
  // ******************************************************************
  reg  [7:0]      dly8_q;
  reg             dly1_q;
  reg  [4:0]      ch_q;
  reg  [2:0]      sf_q;
  reg             mgate_q;
  reg             sgate_q;
  wire            main_ok;
  wire            sub_cand;
  wire            sub_ok;
  wire            m_exp;
  wire            s_exp;
  wire            m_take;
  wire            s_take;

  // candidates, expected slots and what each gate lets through
  assign main_ok  = miss & dly8_q[DLY_TOP];
  assign sub_cand = miss & dly1_q;
  assign sub_ok   = sub_cand & frame_lock_q & (ch_q == SUB_GATE);
  assign m_exp    = (ch_q == MAIN_EXP);
  assign s_exp    = (ch_q == SUB_EXP) && (sf_q == SUB_SF);
  assign m_take   = main_ok & (m_exp | mgate_q);
  assign s_take   = sub_ok & (s_exp | sgate_q);

  // candidate delay line over eight slots
  always @(posedge core_clk) begin
    if (!rst_n) begin
      dly8_q <= 8'h00;
    end else if (tick) begin
      dly8_q <= {dly8_q[6:0], miss};
    end
  end

  // candidate delay line over one slot
  always @(posedge core_clk) begin
    if (!rst_n) begin
      dly1_q <= 1'b0;
    end else if (tick) begin
      dly1_q <= miss;
    end
  end

  // main gate: closes on accepted sync, reopens on a missed one
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mgate_q      <= 1'b1;
      frame_lock_q <= 1'b0;
    end else if (tick) begin
      if (m_take) begin
        mgate_q      <= 1'b0;
        frame_lock_q <= 1'b1;
      end else if (m_exp && frame_lock_q) begin
        mgate_q      <= 1'b1;
        frame_lock_q <= 1'b0;
      end
    end
  end

  // subcom gate: same behaviour, slots from the subcom countdown
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sgate_q    <= 1'b1;
      sub_lock_q <= 1'b0;
    end else if (tick) begin
      if (s_take) begin
        sgate_q    <= 1'b0;
        sub_lock_q <= 1'b1;
      end else if (s_exp && sub_lock_q) begin
        sgate_q    <= 1'b1;
        sub_lock_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // countdowns
  // ******************************************************************
  // main slot count, realigned by accepted main sync
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ch_q <= 5'h00;
    end else if (tick) begin
      if (m_take) begin
        ch_q <= REALIGN;
      end else if (pfsk_last(ch_q)) begin
        ch_q <= 5'h00;
      end else begin
        ch_q <= ch_q + 5'h01;
      end
    end
  end

  // subcom frame count, one step per main frame wrap
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sf_q <= 3'h0;
    end else if (tick) begin
      if (s_take) begin
        sf_q <= SUB_SF;
      end else if (pfsk_last(ch_q) && !m_take) begin
        sf_q <= sf_q + 3'h1;
      end
    end
  end

  // ******************************************************************
  // phase-delayed keying
  // ******************************************************************
  reg  [PH_W-1:0] ph_q;
  reg             ph_run_q;
  wire            key_stb;
  wire [31:0]     dec_ch;
  wire [31:0]     dec_sf;

  // key strobe and the decoded slot and subframe
  assign key_stb = ph_run_q & (ph_q == phase_dly);
  assign dec_ch  = pfsk_dec(ch_q);
  assign dec_sf  = pfsk_dec({2'b00, sf_q});

  // phase counter started by each slot tick
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ph_q     <= {PH_W{1'b0}};
      ph_run_q <= 1'b0;
    end else if (tick) begin
      ph_q     <= {PH_W{1'b0}};
      ph_run_q <= 1'b1;
    end else if (key_stb) begin
      ph_run_q <= 1'b0;
    end else if (ph_run_q) begin
      ph_q <= ph_q + {{(PH_W-1){1'b0}}, 1'b1};
    end
  end

  // main key lines change only on the strobe, so each stands one slot
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hf_key_q <= 32'h0000_0000;
    end else if (key_stb) begin
      hf_key_q <= dec_ch;
    end
  end

  // subcom key lines only in their channel slot of the frame
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sc_key_q <= 8'h00;
    end else if (key_stb) begin
      if (ch_q == SC_KEY) begin
        sc_key_q <= dec_sf[7:0];
      end else begin
        sc_key_q <= 8'h00;
      end
    end
  end

  // ******************************************************************
  // status and record line
  // ******************************************************************
  // slot tick and sync candidate, one cycle each
  always @(posedge core_clk) begin
    if (!rst_n) begin
      slot_clk_q  <= 1'b0;
      sync_cand_q <= 1'b0;
    end else begin
      slot_clk_q  <= tick;
      sync_cand_q <= miss;
    end
  end

  // gate inputs of both sync paths share one record line
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sync_rec_q <= 1'b0;
    end else begin
      sync_rec_q <= tick & (main_ok | sub_ok);
    end
  end

endmodule // pfsk_core

/* File: design/pfsk_map.vh */
`ifndef PFSK_MAP_VH
`define PFSK_MAP_VH
// ********************************************************************
// timing
// ********************************************************************
`define PFSK_CLK_NS        10
`define PFSK_SLOT_NS       62500
`define PFSK_HF_OFF_NS     1937500
`define PFSK_SC_OFF_NS     15937500
`define PFSK_SLOT_CYC      (`PFSK_SLOT_NS / `PFSK_CLK_NS)
// ********************************************************************
// frame layout
// ********************************************************************
`define PFSK_FRAME_SLOTS   32
`define PFSK_SUB_FRAMES    8
`define PFSK_MAIN_DLY      8
`define PFSK_MAIN_EXP_CH   5'h08
`define PFSK_SUB_EXP_CH    5'h00
`define PFSK_SUB_GATE_CH   5'h00
`define PFSK_SUB_EXP_SF    3'h0
`define PFSK_LAST_CH       5'h1f
`define PFSK_REALIGN_CH    5'h09
`define PFSK_SC_KEY_CH     5'h0f
`endif

/* File: tb/pfsk_props.sv */
`timescale 1ns/1ps
module pfsk_props #(
  parameter SLOT_CYC = 16,
  parameter PH_W     = 16
) (
  // clock, reset, inputs
  input logic            core_clk,
  input logic            rst_n,
  input logic            data_pulse,
  input logic [PH_W-1:0] phase_dly,
  // outputs watched
  input logic [31:0]     hf_key_q,
  input logic [7:0]      sc_key_q,
  input logic            slot_clk_q,
  input logic            sync_cand_q,
  input logic            frame_lock_q,
  input logic            sub_lock_q,
  input logic            sync_rec_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // key lines, ticks and sync relations
  a_key_onehot: assert property ($onehot0(hf_key_q))
    else $error("main keys not one-hot");
  a_sub_onehot: assert property ($onehot0(sc_key_q))
    else $error("subcom keys not one-hot");
  a_sub_slot: assert property (|sc_key_q |-> hf_key_q[15])
    else $error("subcom key outside its slot");
  a_tick_pulse: assert property (slot_clk_q |=> !slot_clk_q)
    else $error("slot tick longer than one cycle");
  a_cand_tick: assert property (sync_cand_q |-> slot_clk_q)
    else $error("candidate without slot tick");
  a_key_stands: assert property ($changed(hf_key_q) |=> $stable(hf_key_q)[*6])
    else $error("main key too short");
  a_rec_cause: assert property (sync_rec_q |-> sync_cand_q ||
    $past(sync_cand_q) || $past(sync_cand_q, 2))
    else $error("record pulse without candidate");
  a_lock_cause: assert property ($rose(frame_lock_q) |-> sync_rec_q ||
    $past(sync_rec_q) || $past(sync_rec_q, 2))
    else $error("lock without validated sync");
  a_sub_gated: assert property ($rose(sub_lock_q) |-> frame_lock_q)
    else $error("subcom lock before main lock");
  a_realign: assert property ($rose(frame_lock_q) |-> ##[1:40] hf_key_q[9])
    else $error("countdown not realigned");
endmodule // pfsk_props
bind pfsk_core pfsk_props #(.SLOT_CYC(SLOT_CYC), .PH_W(PH_W)) i_props (
  .core_clk, .rst_n, .data_pulse, .phase_dly, .hf_key_q, .sc_key_q,
  .slot_clk_q, .sync_cand_q, .frame_lock_q, .sub_lock_q, .sync_rec_q);

/* File: tb/pfsk_train.sv */
`timescale 1ns/1ps
module pfsk_train #(
  parameter SLOT_CYC = 16
) (
  // clock, reset, scenario controls
  input  wire core_clk,
  input  wire rst_n,
  input  wire sync_en,
  input  wire sub_en,
  input  wire false_en,
  // pulse train
  output reg  data_pulse
);
  int cyc_q, ch_q, fr_q;
  wire miss;
  // gaps: channels 1 and 9, channel 32 of last subframe, false pair
  assign miss = (sync_en && (ch_q == 0 || ch_q == 8)) ||
    (sub_en && ch_q == 31 && fr_q == 7) ||
    (false_en && (ch_q == 20 || ch_q == 28));
  // slot timing; pulse early in slot, line low between pulses
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cyc_q <= 0; ch_q <= 0; fr_q <= 0; data_pulse <= 1'b0;
    end else begin
      cyc_q <= (cyc_q == SLOT_CYC - 1) ? 0 : cyc_q + 1;
      if (cyc_q == SLOT_CYC - 1) begin
        ch_q <= (ch_q + 1) % 32;
        if (ch_q == 31) fr_q <= (fr_q + 1) % 8;
      end
      data_pulse <= cyc_q >= 2 && cyc_q < 6 && !miss;
    end
  end
endmodule // pfsk_train

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int SLOT = 16;
  logic core_clk = 0, rst_n = 0, sync_en = 0, sub_en = 0, false_en = 0;
  logic data_pulse, slot_clk_q, sync_cand_q, frame_lock_q, sub_lock_q;
  logic sync_rec_q;
  logic [15:0] phase_dly = 16'h0003;
  logic [31:0] hf_key_q;
  logic [7:0]  sc_key_q;
  wire  [39:0] keys = {sc_key_q, hf_key_q};
  int errors = 0, cmp_count = 0, hi, per;
  always #5 core_clk = ~core_clk;
  pfsk_train #(.SLOT_CYC(SLOT)) i_train (.core_clk(core_clk), .rst_n(rst_n),
    .sync_en(sync_en), .sub_en(sub_en), .false_en(false_en),
    .data_pulse(data_pulse));
  pfsk_core #(.SLOT_CYC(SLOT), .PH_W(16)) i_dut (.core_clk(core_clk),
    .rst_n(rst_n), .data_pulse(data_pulse), .phase_dly(phase_dly),
    .hf_key_q(hf_key_q), .sc_key_q(sc_key_q), .slot_clk_q(slot_clk_q),
    .sync_cand_q(sync_cand_q), .frame_lock_q(frame_lock_q),
    .sub_lock_q(sub_lock_q), .sync_rec_q(sync_rec_q));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // high time and period of one key line
  task automatic gap(input int b);
    int i;
    hi = 0; per = 0;
    for (i = 0; i < 9000 && keys[b] !== 1'b0; i++) @(negedge core_clk);
    for (i = 0; i < 9000 && keys[b] !== 1'b1; i++) @(negedge core_clk);
    while (keys[b] === 1'b1 && hi < 9000) begin
      hi++; per++; @(negedge core_clk);
    end
    while (keys[b] !== 1'b1 && per < 9000) begin
      per++; @(negedge core_clk);
    end
  endtask
  // record and candidate pulses over one frame
  task automatic t_rec(input int n_rec, input int n_cand);
    int i, r, c;
    r = 0;
    c = 0;
    for (i = 0; i < 32 * SLOT; i++) begin
      @(negedge core_clk);
      r += (sync_rec_q === 1'b1);
      c += (sync_cand_q === 1'b1);
    end
    chk(r, n_rec);
    chk(c, n_cand);
  endtask
  task automatic wait_lock(input logic sub, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && (sub ? sub_lock_q : frame_lock_q) !== v; i++)
      @(negedge core_clk);
  endtask
  task automatic t_lock();
    @(posedge core_clk); sync_en <= 1'b1;
    wait_lock(0, 1, 3000); chk(frame_lock_q, 1);
    gap(0); chk(hi, SLOT); chk(per, 32 * SLOT);
    t_rec(1, 2);
  endtask
  // key change lags the slot tick by the phase setting plus one cycle
  task automatic t_phase(input logic [15:0] ph);
    int n;
    logic [31:0] k;
    @(posedge core_clk); phase_dly <= ph;
    repeat (2 * SLOT) @(negedge core_clk);
    for (n = 0; n < SLOT && slot_clk_q !== 1'b1; n++) @(negedge core_clk);
    k = hf_key_q; n = 0;
    while (hf_key_q === k && n < SLOT) begin n++; @(negedge core_clk); end
    chk(n, ph + 1);
  endtask
  task automatic t_false();
    @(posedge core_clk); false_en <= 1'b1;
    repeat (64 * SLOT) @(negedge core_clk);
    chk(frame_lock_q, 1);
    gap(0); chk(per, 32 * SLOT);
    t_rec(2, 4);
    @(posedge core_clk);
    false_en <= 1'b0;
  endtask
  task automatic t_sub();
    @(posedge core_clk); sub_en <= 1'b1;
    wait_lock(1, 1, 12000); chk(sub_lock_q, 1);
    gap(32); chk(hi, SLOT); chk(per, 256 * SLOT);
  endtask
  task automatic t_loss();
    @(posedge core_clk); sync_en <= 1'b0;
    wait_lock(0, 0, 2000); chk(frame_lock_q, 0);
    @(posedge core_clk); sync_en <= 1'b1;
    wait_lock(0, 1, 3000); chk(frame_lock_q, 1);
  endtask
  task automatic results();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (9) @(posedge core_clk);
    @(negedge core_clk);
    chk(hf_key_q, 0);
    chk({sc_key_q, slot_clk_q, sync_cand_q}, 0);
    chk({frame_lock_q, sub_lock_q, sync_rec_q}, 0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    t_lock(); t_phase(16'h0003); t_phase(16'h0009);
    t_false(); t_sub(); t_loss();
    results();
  end
  // watchdog
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule // tb_top
